/* File: src/tss_link_if.sv */
// Words passed between the system-clock logic and the link-clock shifter
`timescale 1ns/1ps
interface tss_link_if;
	logic [7:0] tx_word;
	logic [7:0] rx_word;
	logic       rx_tgl;
	logic       clr;

	modport core  (output tx_word, output clr, input rx_word, input rx_tgl);
	modport shift (input tx_word, input clr, output rx_word, output rx_tgl);
endinterface

/* File: src/tss_pkg.sv */
// Shared constants for the touch slider serial port and readiness sequencer
package tss_pkg;
	localparam int unsigned CLK_KHZ   = 20000;
	localparam int unsigned FLOAT_MS  = 20;
	localparam int unsigned CAL_MS    = 525;
	localparam int unsigned WAKE_US   = 400;
	localparam int unsigned SETTLE_US = 500;
	localparam int unsigned BYTE_BITS = 8;
	localparam int unsigned CNT_W     = 24;

	localparam logic [CNT_W-1:0] FLOAT_CYC  = CNT_W'(FLOAT_MS * CLK_KHZ);
	localparam logic [CNT_W-1:0] CAL_CYC    = CNT_W'(CAL_MS * CLK_KHZ);
	localparam logic [CNT_W-1:0] WAKE_CYC   = CNT_W'((WAKE_US * CLK_KHZ + 999) / 1000);
	localparam logic [CNT_W-1:0] SETTLE_CYC = CNT_W'((SETTLE_US * CLK_KHZ + 999) / 1000);
	localparam logic [CNT_W-1:0] CNT_ONE    = 24'h000001;
	localparam logic [CNT_W-1:0] CNT_ZERO   = 24'h000000;
	localparam logic [7:0]       BYTE_ZERO  = 8'h00;

	typedef enum logic [2:0] {
		PWR_FLOAT,
		PWR_CAL,
		IDLE,
		SLEEP,
		WAKE,
		SETTLE,
		BURST
	} tss_state_type;
endpackage

/* File: src/tss_shift.sv */
// Link-clock byte shifter, clock idles high, MSB first
`timescale 1ns/1ps
module tss_shift (
	input  wire logic   sck,
	input  wire logic   ss_n,
	input  wire logic   mosi,
	output logic        miso,
	tss_link_if.shift   lnk
);
	logic [2:0] rx_cnt_q;
	logic [2:0] tx_cnt_q;
	logic [6:0] rx_sh_q;
	logic       last_bit;

	assign last_bit = (rx_cnt_q == 3'h7);

	////////////////////////////////////////////////////////////////////////////
	// Sampling on the rising edge; the frame select clears counts since the
	// link clock may stop between frames
	always_ff @(posedge sck or posedge ss_n) begin
		if (ss_n) begin
			rx_cnt_q <= 3'h0;
		end else begin
			rx_cnt_q <= rx_cnt_q + 3'h1;
		end
	end

	always_ff @(posedge sck) begin
		rx_sh_q <= {rx_sh_q[5:0], mosi};
	end

	// Word stays put for eight link clocks, so the core samples it after the toggle.
	// Only the core reset clears it: a frame end must not undo a byte the core has not seen
	always_ff @(posedge sck or posedge lnk.clr) begin
		if (lnk.clr) begin
			lnk.rx_tgl  <= 1'b0;
			lnk.rx_word <= 8'h00;
		end else if (last_bit) begin
			lnk.rx_word <= {rx_sh_q, mosi};
			lnk.rx_tgl  <= ~lnk.rx_tgl;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Output bit advances on every falling edge; the first one puts out the MSB
	always_ff @(negedge sck or posedge ss_n) begin
		if (ss_n) begin
			tx_cnt_q <= 3'h7;
		end else begin
			tx_cnt_q <= tx_cnt_q + 3'h1;
		end
	end

	assign miso = lnk.tx_word[~tx_cnt_q];
endmodule

/* File: src/tss_top.sv */
// Touch slider serial slave with power-up readiness and wake settling sequencer
// Contract
// - Slave only; data output released to high impedance outside each shift.
// - Device drives a ready output telling host when a transfer may start.
// - After power-up the ready output floats about 20 ms, then goes low.
// - Ready stays low about 525 ms for calibration, then goes high.
// - Leaving sleep: 400 us wake, then 500 us settling before a burst.
// - A burst with no preceding sleep starts without the settling delay.
// - Transfers are eight-bit bytes, MSB first, both directions at once.
// - Clock idles high; outputs change on falling, inputs sampled on rising edge.
`timescale 1ns/1ps
module tss_top #(
	parameter logic [23:0] FLOAT_CYC  = tss_pkg::FLOAT_CYC,
	parameter logic [23:0] CAL_CYC    = tss_pkg::CAL_CYC,
	parameter logic [23:0] WAKE_CYC   = tss_pkg::WAKE_CYC,
	parameter logic [23:0] SETTLE_CYC = tss_pkg::SETTLE_CYC
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	input  wire logic       sck,
	input  wire logic       ss_n,
	input  wire logic       mosi,
	output logic            miso_o,
	output logic            miso_oe,
	output logic            host_go_signal_o,
	output logic            host_go_signal_oe,
	input  wire logic [7:0] tx_data,
	output logic [7:0]      rx_data,
	output logic            rx_valid,
	input  wire logic       sleep_req,
	input  wire logic       wake_req,
	input  wire logic       burst_req,
	input  wire logic       burst_done,
	output logic            burst_start,
	output logic            asleep
);
	tss_link_if lnk ();

	tss_pkg::tss_state_type st_q;
	tss_pkg::tss_state_type st_d;
	logic [23:0]            cnt_q;
	logic [23:0]            cnt_lim;
	logic                   timed;
	logic                   cnt_end;
	logic                   port_en_q;
	logic                   ss_s1_q;
	logic                   ss_s2_q;
	logic                   tg_s1_q;
	logic                   tg_s2_q;
	logic                   tg_s3_q;
	logic                   byte_evt;
	logic [7:0]             tx_q;
	logic                   go_q;
	logic                   go_oe_q;
	logic                   shift_miso;
	logic                   lnk_clr_q;

	////////////////////////////////////////////////////////////////////////////
	// Link-clock shifter
	tss_shift u_shift (
		.sck  (sck),
		.ss_n (ss_n),
		.mosi (mosi),
		.miso (shift_miso),
		.lnk  (lnk)
	);

	// Released whenever no frame is open or the sequencer was not going to the idle state at the last clock
	assign miso_oe = ~ss_n & port_en_q;
	assign miso_o  = shift_miso & miso_oe;

	////////////////////////////////////////////////////////////////////////////
	// Crossings: frame select level and received-byte toggle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ss_s1_q <= 1'b1;
			ss_s2_q <= 1'b1;
			tg_s1_q <= 1'b0;
			tg_s2_q <= 1'b0;
			tg_s3_q <= 1'b0;
		end else if (ce) begin
			ss_s1_q <= ss_n;
			ss_s2_q <= ss_s1_q;
			tg_s1_q <= lnk.rx_tgl;
			tg_s2_q <= tg_s1_q;
			tg_s3_q <= tg_s2_q;
		end
	end

	assign byte_evt = tg_s2_q ^ tg_s3_q;

	// Link-side clear follows the core reset; the host keeps the link clock still
	// while ready floats, so its release never meets a link edge
	always_ff @(posedge clk) begin
		lnk_clr_q <= ~rst_n;
	end

	assign lnk.clr = lnk_clr_q;

	// Transmit word only changes while no frame is open, so the shifter sees it stable
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tx_q <= tss_pkg::BYTE_ZERO;
		end else if (ce && ss_s2_q) begin
			tx_q <= tx_data;
		end
	end

	assign lnk.tx_word = tx_q;

	// Received word holds until the next byte completes, so it is steady when the toggle lands
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rx_data  <= tss_pkg::BYTE_ZERO;
			rx_valid <= 1'b0;
		end else if (ce) begin
			rx_valid <= byte_evt & port_en_q;
			if (byte_evt && port_en_q) begin
				rx_data <= lnk.rx_word;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Readiness sequencer
	assign timed = (st_q == tss_pkg::PWR_FLOAT) || (st_q == tss_pkg::PWR_CAL)
		|| (st_q == tss_pkg::WAKE) || (st_q == tss_pkg::SETTLE);
	assign cnt_lim = (st_q == tss_pkg::PWR_FLOAT) ? FLOAT_CYC :
		(st_q == tss_pkg::PWR_CAL) ? CAL_CYC :
		(st_q == tss_pkg::WAKE) ? WAKE_CYC : SETTLE_CYC;
	assign cnt_end = timed && (cnt_q == cnt_lim - tss_pkg::CNT_ONE);

	always_comb begin
		st_d = st_q;
		case (st_q)
			tss_pkg::PWR_FLOAT: if (cnt_end) st_d = tss_pkg::PWR_CAL;
			tss_pkg::PWR_CAL:   if (cnt_end) st_d = tss_pkg::IDLE;
			tss_pkg::IDLE: begin
				if (burst_req) begin
					st_d = tss_pkg::BURST;
				end else if (sleep_req && ss_s2_q) begin
					st_d = tss_pkg::SLEEP;
				end
			end
			tss_pkg::SLEEP:  if (wake_req || burst_req) st_d = tss_pkg::WAKE;
			tss_pkg::WAKE:   if (cnt_end) st_d = tss_pkg::SETTLE;
			tss_pkg::SETTLE: if (cnt_end) st_d = tss_pkg::BURST;
			tss_pkg::BURST:  if (burst_done) st_d = tss_pkg::IDLE;
			default:         st_d = tss_pkg::PWR_FLOAT;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_q  <= tss_pkg::PWR_FLOAT;
			cnt_q <= tss_pkg::CNT_ZERO;
		end else if (ce) begin
			st_q  <= st_d;
			cnt_q <= (st_d != st_q) ? tss_pkg::CNT_ZERO : cnt_q + tss_pkg::CNT_ONE;
		end
	end

	// Ready: floats at power-up and while waking, high only when idle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			go_q        <= 1'b0;
			go_oe_q     <= 1'b0;
			port_en_q   <= 1'b0;
			burst_start <= 1'b0;
		end else if (ce) begin
			go_q        <= (st_d == tss_pkg::IDLE);
			go_oe_q     <= (st_d != tss_pkg::PWR_FLOAT) && (st_d != tss_pkg::WAKE);
			port_en_q   <= (st_d == tss_pkg::IDLE);
			burst_start <= (st_d == tss_pkg::BURST) && (st_q != tss_pkg::BURST);
		end
	end

	assign host_go_signal_o  = go_q & go_oe_q;
	assign host_go_signal_oe = go_oe_q;
	assign asleep            = (st_q == tss_pkg::SLEEP);

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_wake_done;
		$past(st_q) == tss_pkg::WAKE && st_q == tss_pkg::SETTLE;
	endsequence

	sequence s_settle_done;
		$past(st_q) == tss_pkg::SETTLE && st_q == tss_pkg::BURST;
	endsequence

	a_miso_release: assert property (ss_n |-> !miso_oe)
		else $error("data output driven outside a frame");
	a_ready_idle: assert property ($past(st_q) == tss_pkg::IDLE && st_q == tss_pkg::IDLE
		|-> host_go_signal_o && host_go_signal_oe)
		else $error("ready not high while idle");
	a_float_length: assert property ($past(st_q) == tss_pkg::PWR_FLOAT
		&& st_q == tss_pkg::PWR_CAL |-> $past(cnt_q) == FLOAT_CYC - 24'h000001)
		else $error("power-up float length wrong");
	a_float_undriven: assert property (st_q == tss_pkg::PWR_FLOAT |-> !host_go_signal_oe)
		else $error("ready driven during power-up float");
	a_wake_float: assert property (st_q == tss_pkg::WAKE |-> !host_go_signal_oe)
		else $error("ready driven while waking");
	a_cal_length: assert property ($past(st_q) == tss_pkg::PWR_CAL
		&& st_q == tss_pkg::IDLE |-> $past(cnt_q) == CAL_CYC - 24'h000001)
		else $error("calibration length wrong");
	a_cal_low: assert property (st_q == tss_pkg::PWR_CAL && $past(st_q) == tss_pkg::PWR_CAL
		|-> host_go_signal_oe && !host_go_signal_o)
		else $error("ready not low during calibration");
	a_wake_time: assert property (s_wake_done |-> $past(cnt_q) == WAKE_CYC - 24'h000001)
		else $error("wake time wrong");
	a_settle_time: assert property (s_settle_done |-> $past(cnt_q) == SETTLE_CYC - 24'h000001
		##0 burst_start)
		else $error("settle time wrong");
	a_direct_burst: assert property (st_q == tss_pkg::IDLE && burst_req && ce
		|=> st_q == tss_pkg::BURST && burst_start)
		else $error("burst delayed without sleep");
	a_quiet_port: assert property (!port_en_q |-> !miso_oe ##1 !rx_valid)
		else $error("port active while not ready");
endmodule

/* File: verif/tb.sv */
// Self-checking bench for the touch slider serial slave
`timescale 1ns/1ps
module tb;
	localparam logic [23:0] FLT = 24'h000014;
	localparam logic [23:0] CAL = 24'h000028;
	localparam logic [23:0] WAK = 24'h000008;
	localparam logic [23:0] SET = 24'h00000A;
	typedef struct {logic [7:0] tx; logic [7:0] mo;} tss_row_type;
	logic        clk, rst_n, ce, sck, ss_n, mosi, miso_o, miso_oe, go_o, go_oe;
	logic        rx_valid, sleep_req, wake_req, burst_req, burst_done, burst_start, asleep;
	logic [7:0]  tx_data, rx_data, got;
	int          n_fail, num_checks, n_rxv, n_oe, n, k;
	tss_row_type rows [3] = '{'{8'hA5, 8'h3C}, '{8'h01, 8'h80}, '{8'hFF, 8'h00}};

	tss_top #(.FLOAT_CYC(FLT), .CAL_CYC(CAL), .WAKE_CYC(WAK), .SETTLE_CYC(SET)) DUT (
		.clk(clk), .rst_n(rst_n), .ce(ce), .sck(sck), .ss_n(ss_n), .mosi(mosi),
		.miso_o(miso_o), .miso_oe(miso_oe), .host_go_signal_o(go_o),
		.host_go_signal_oe(go_oe), .tx_data(tx_data), .rx_data(rx_data),
		.rx_valid(rx_valid), .sleep_req(sleep_req), .wake_req(wake_req),
		.burst_req(burst_req), .burst_done(burst_done), .burst_start(burst_start),
		.asleep(asleep));
	tss_host host (.sck(sck), .ss_n(ss_n), .mosi(mosi), .miso(miso_o), .miso_oe(miso_oe));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	always @(posedge clk) begin
		if (rx_valid === 1'b1) n_rxv++;
		if (miso_oe === 1'b1) n_oe++;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_in(input string nm, input int lo, input int hi, input int g);
		num_checks++;
		if (g < lo || g > hi) begin
			n_fail++;
			$display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, g);
		end
	endtask
	// Samples one step after the edge so the design's updates have landed
	task automatic cyc(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask
	task automatic wait_start(output int c);
		c = 0;
		while (burst_start !== 1'b1 && c < 100) begin
			cyc(1);
			c++;
		end
	endtask
	task automatic end_burst;
		@(posedge clk) burst_done <= 1'b1;
		@(posedge clk) burst_done <= 1'b0;
		cyc(2);
		chk("go after burst", 1, go_o);
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Whole sequence needs about 200 cycles; allow far more
	initial begin
		#500000;
		n_fail++;
		$display("watchdog expired");
		conclude;
	end

	initial begin
		{n_fail, num_checks, n_rxv, n_oe} = '0;
		{rst_n, sleep_req, wake_req, burst_req, burst_done} = '0;
		ce = 1'b1;
		tx_data = 8'h00;
		cyc(20);
		chk("go_oe in reset", 0, go_oe);
		chk("miso_oe in reset", 0, miso_oe);
		@(posedge clk) rst_n <= 1'b1;
		cyc(FLT - 2);
		chk("go_oe floating", 0, go_oe);
		cyc(4);
		chk("go_oe driven", 1, go_oe);
		chk("go low", 0, go_o);
		// Deliberate traffic while not ready: must be dropped
		#7 host.xfer(8'h5A, got);
		cyc(2);
		chk_in("bytes in cal", 0, 0, n_rxv);
		chk_in("miso drive in cal", 0, 0, n_oe);
		cyc(CAL - 20);
		chk("go during cal", 0, go_o);
		cyc(12);
		chk("go after cal", 1, go_o);
		$display("test power_up done");
		foreach (rows[i]) begin
			@(posedge clk) tx_data <= rows[i].tx;
			cyc(3);
			k = n_rxv;
			#7 host.xfer(rows[i].mo, got);
			cyc(6);
			chk("rx_data", rows[i].mo, rx_data);
			chk("host byte", rows[i].tx, got);
			chk_in("rx_valid pulses", k + 1, k + 1, n_rxv);
			chk("miso_oe after frame", 0, miso_oe);
		end
		$display("test bytes done");
		// Clock enable low must hold the idle state even with a burst asked for
		@(posedge clk) begin
			ce        <= 1'b0;
			burst_req <= 1'b1;
		end
		cyc(4);
		chk("go while frozen", 1, go_o);
		chk("start while frozen", 0, burst_start);
		@(posedge clk) ce <= 1'b1;
		wait_start(n);
		chk_in("burst latency", 1, 2, n);
		chk("go in burst", 0, go_o);
		@(posedge clk) burst_req <= 1'b0;
		end_burst;
		$display("test burst done");
		@(posedge clk) sleep_req <= 1'b1;
		cyc(3);
		chk("asleep", 1, asleep);
		@(posedge clk) begin
			sleep_req <= 1'b0;
			wake_req <= 1'b1;
		end
		@(posedge clk) wake_req <= 1'b0;
		cyc(2);
		chk("go_oe waking", 0, go_oe);
		cyc(WAK + 2);
		chk("go_oe settling", 1, go_oe);
		chk("go settling", 0, go_o);
		wait_start(n);
		chk_in("wake latency", WAK + SET, WAK + SET + 1, n + WAK + 4);
		end_burst;
		$display("test wake done");
		// Reset in mid-run must drop the ready pin and restart the power-up float
		@(posedge clk) rst_n <= 1'b0;
		cyc(2);
		chk("go_oe in rerun reset", 0, go_oe);
		chk("rx_data in reset", 8'h00, rx_data);
		chk("asleep in reset", 0, asleep);
		@(posedge clk) rst_n <= 1'b1;
		cyc(FLT - 2);
		chk("go_oe refloat", 0, go_oe);
		cyc(4);
		chk("go_oe redriven", 1, go_oe);
		chk("go low again", 0, go_o);
		$display("test reset done");
		conclude;
	end
endmodule

/* File: verif/tss_host.sv */
// Host controller model: link-clock master for the serial port
`timescale 1ns/1ps
module tss_host (
	output logic      sck,
	output logic      ss_n,
	output logic      mosi,
	input  wire logic miso,
	input  wire logic miso_oe
);
	logic last_q;

	initial begin
		sck    = 1'b1;
		ss_n   = 1'b1;
		mosi   = 1'b0;
		last_q = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Clock stands high between frames; a released data line reads as the inverted last bit
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		ss_n = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			#24 sck = 1'b0;
			mosi = tx[i];
			#24 sck = 1'b1;
			last_q = miso_oe ? miso : ~last_q;
			rx = {rx[6:0], last_q};
		end
		#24 ss_n = 1'b1;
		mosi = ~mosi;
	endtask
endmodule
